// File: hw/irq_ctrl_cfg.svh
// register offsets, field positions, reset values and edge codes for the interrupt control block
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH
`define IRQ_ADDR_EDGE_SEL     4'h0
`define IRQ_ADDR_CTRL_FIRST   4'h1
`define IRQ_ADDR_CTRL_SECOND  4'h2
`define IRQ_ADDR_VECTOR       4'h3
`define IRQ_RST_EDGE_SEL      8'h00
`define IRQ_RST_CTRL_FIRST    8'h00
`define IRQ_RST_CTRL_SECOND   8'h00
// first control register bits
`define IRQ_B_GLOBAL_EN       0
`define IRQ_B_EXT_EN          1
`define IRQ_B_CONV_EN         2
`define IRQ_B_AUTO_EN         3
`define IRQ_B_EXT_FLAG        4
`define IRQ_B_CONV_FLAG       5
`define IRQ_B_AUTO_FLAG       6
// second control register bits
`define IRQ_B_TB0_EN          0
`define IRQ_B_TB1_EN          1
`define IRQ_B_PER_EN          2
`define IRQ_B_CMPA_EN         3
`define IRQ_B_TB0_FLAG        4
`define IRQ_B_TB1_FLAG        5
`define IRQ_B_PER_FLAG        6
`define IRQ_B_CMPA_FLAG       7
// edge select codes
`define IRQ_EDGE_OFF          2'b00
`define IRQ_EDGE_RISE         2'b01
`define IRQ_EDGE_FALL         2'b10
`define IRQ_EDGE_BOTH         2'b11
`define IRQ_NUM_SRC           7
`endif

// File: hw/irq_ctrl_pkg.sv
// types for the interrupt control block
`default_nettype none
package irq_ctrl_pkg;
  // source index doubles as priority, 0 highest
  typedef enum logic [2:0]
  {
    SRC_EXT,
    SRC_CONV,
    SRC_AUTO,
    SRC_TB0,
    SRC_TB1,
    SRC_PER,
    SRC_CMPA,
    SRC_NONE
  } irq_src_t;
  typedef enum logic [1:0]
  {
    ST_RUN,
    ST_REQ
  } vec_state_t;
endpackage
`default_nettype wire

// File: hw/irq_edge_detect.sv
// external pin edge detector with selectable edge type
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_cfg.svh"
module irq_edge_detect
(
  input  wire logic       clk_in,      // system clock
  input  wire logic       reset_n_in,  // async reset, active low
  input  wire logic       pin_in,      // external interrupt pin
  input  wire logic [1:0] edge_sel_in, // edge type select
  output logic            event_out    // one-cycle edge event
);
  logic pin_r;
  logic armed_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pin_r <= 1'b0;
    else
      pin_r <= pin_in;
  end

  // no edge before the first sampled level
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      armed_r <= 1'b0;
    else
      armed_r <= 1'b1;
  end

  always_comb
  begin
    case (edge_sel_in)
      `IRQ_EDGE_RISE: event_out = armed_r & pin_in & ~pin_r;
      `IRQ_EDGE_FALL: event_out = armed_r & ~pin_in & pin_r;
      `IRQ_EDGE_BOTH: event_out = armed_r & (pin_in ^ pin_r);
      default:        event_out = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: hw/irq_request_ctrl.sv
// interrupt request, enable, priority and vector logic
// Functional notes
// - timer, converter, auto conversion and time bases each have a flag and enable
// - selected transitions on the external pin set the external flag
// - edge select: 00 off, 01 rising, 10 falling, 11 both
// - edge select register bits 7..2 read as zero
// - control registers hold per-source enables and request flags
// - auto conversion flag reads 1 when pending, 0 when not
// - a serviced request diverts the core to that source's handler
// - flags set regardless of enable; vectoring only when enabled
// - global enable low blocks every interrupt
// - taking an interrupt clears the global enable
// - any flag becoming set wakes the device
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_cfg.svh"
module irq_request_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input  wire logic              clk_in,          // 50 MHz system clock
  input  wire logic              reset_n_in,      // async reset, active low
  input  wire logic [ADDR_W-1:0] addr_in,         // register address
  input  wire logic [7:0]        wdata_in,        // write data
  input  wire logic              wr_in,           // write strobe
  input  wire logic              rd_in,           // read strobe
  output logic      [7:0]        rdata_out,       // read data, cycle after strobe
  input  wire logic              ext_pin_in,      // external interrupt pin
  input  wire logic              conv_done_in,    // converter end pulse
  input  wire logic              autoconv_in,     // auto conversion event pulse
  input  wire logic              timebase0_in,    // time base 0 pulse
  input  wire logic              timebase1_in,    // time base 1 pulse
  input  wire logic              period_match_in, // timer period match pulse
  input  wire logic              compare_a_in,    // timer compare A pulse
  output logic                   irq_req_out,     // vector request to core
  output irq_ctrl_pkg::irq_src_t irq_src_out,     // source being requested
  output logic [2:0]             irq_vector_out,  // vector index
  input  wire logic              irq_ack_in,      // core entered handler
  output logic                   wake_out,        // wake pulse from sleep/idle
  output logic                   irq_out          // level interrupt line
);
  import irq_ctrl_pkg::*;

  logic [1:0] edge_sel_r;
  logic [6:0] enable_r;    // index per irq_src_t
  logic [6:0] flag_r;
  logic       global_en_r;
  logic [7:0] rdata_r;
  logic       wake_r;
  logic       req_r;
  irq_src_t   src_r;
  vec_state_t state_r;
  logic       ext_event;
  logic [6:0] events;
  logic [6:0] set_vec;
  logic [6:0] clr_vec;
  logic [6:0] pending;
  irq_src_t   winner;
  logic       take;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    wr_hit = wr_in && (addr_in == a);
  endfunction

  irq_edge_detect u_edge
  (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .pin_in      (ext_pin_in),
    .edge_sel_in (edge_sel_r),
    .event_out   (ext_event)
  );

  assign events = {compare_a_in, period_match_in, timebase1_in, timebase0_in,
                   autoconv_in, conv_done_in, ext_event};

  // software clear by writing zero to the flag; hardware set wins
  always_comb
  begin
    clr_vec = '0;
    if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_FIRST)))
    begin
      clr_vec[SRC_EXT]  = ~wdata_in[`IRQ_B_EXT_FLAG];
      clr_vec[SRC_CONV] = ~wdata_in[`IRQ_B_CONV_FLAG];
      clr_vec[SRC_AUTO] = ~wdata_in[`IRQ_B_AUTO_FLAG];
    end
    if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_SECOND)))
    begin
      clr_vec[SRC_TB0]  = ~wdata_in[`IRQ_B_TB0_FLAG];
      clr_vec[SRC_TB1]  = ~wdata_in[`IRQ_B_TB1_FLAG];
      clr_vec[SRC_PER]  = ~wdata_in[`IRQ_B_PER_FLAG];
      clr_vec[SRC_CMPA] = ~wdata_in[`IRQ_B_CMPA_FLAG];
    end
    if (take)
      clr_vec[src_r] = 1'b1;
  end

  // software may also set a flag by writing one
  always_comb
  begin
    set_vec = events;
    if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_FIRST)))
    begin
      set_vec[SRC_EXT]  = set_vec[SRC_EXT]  | wdata_in[`IRQ_B_EXT_FLAG];
      set_vec[SRC_CONV] = set_vec[SRC_CONV] | wdata_in[`IRQ_B_CONV_FLAG];
      set_vec[SRC_AUTO] = set_vec[SRC_AUTO] | wdata_in[`IRQ_B_AUTO_FLAG];
    end
    if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_SECOND)))
    begin
      set_vec[SRC_TB0]  = set_vec[SRC_TB0]  | wdata_in[`IRQ_B_TB0_FLAG];
      set_vec[SRC_TB1]  = set_vec[SRC_TB1]  | wdata_in[`IRQ_B_TB1_FLAG];
      set_vec[SRC_PER]  = set_vec[SRC_PER]  | wdata_in[`IRQ_B_PER_FLAG];
      set_vec[SRC_CMPA] = set_vec[SRC_CMPA] | wdata_in[`IRQ_B_CMPA_FLAG];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_NUM_SRC; gi++)
    begin : g_flag
      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
          flag_r[gi] <= 1'b0;
        else if (set_vec[gi])
          flag_r[gi] <= 1'b1;
        else if (clr_vec[gi])
          flag_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      edge_sel_r <= 2'(`IRQ_RST_EDGE_SEL);
    else if (wr_hit(ADDR_W'(`IRQ_ADDR_EDGE_SEL)))
      edge_sel_r <= wdata_in[1:0];
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      enable_r <= '0;
    else
    begin
      if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_FIRST)))
      begin
        enable_r[SRC_EXT]  <= wdata_in[`IRQ_B_EXT_EN];
        enable_r[SRC_CONV] <= wdata_in[`IRQ_B_CONV_EN];
        enable_r[SRC_AUTO] <= wdata_in[`IRQ_B_AUTO_EN];
      end
      if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_SECOND)))
      begin
        enable_r[SRC_TB0]  <= wdata_in[`IRQ_B_TB0_EN];
        enable_r[SRC_TB1]  <= wdata_in[`IRQ_B_TB1_EN];
        enable_r[SRC_PER]  <= wdata_in[`IRQ_B_PER_EN];
        enable_r[SRC_CMPA] <= wdata_in[`IRQ_B_CMPA_EN];
      end
    end
  end

  // hardware clear on entry takes precedence over a same-cycle write
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      global_en_r <= 1'b0;
    else if (take)
      global_en_r <= 1'b0;
    else if (wr_hit(ADDR_W'(`IRQ_ADDR_CTRL_FIRST)))
      global_en_r <= wdata_in[`IRQ_B_GLOBAL_EN];
  end

  assign pending = flag_r & enable_r;

  always_comb
  begin
    winner = SRC_NONE;
    for (int i = `IRQ_NUM_SRC - 1; i >= 0; i--)
      if (pending[i])
        winner = irq_src_t'(i);
  end

  assign take = irq_req_out && irq_ack_in;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= ST_RUN;
      req_r   <= 1'b0;
      src_r   <= SRC_NONE;
    end
    else
    begin
      case (state_r)
        ST_RUN:
        begin
          if (global_en_r && winner != SRC_NONE)
          begin
            state_r <= ST_REQ;
            req_r   <= 1'b1;
            src_r   <= winner;
          end
        end
        ST_REQ:
        begin
          if (irq_ack_in || !global_en_r || !pending[src_r])
          begin
            state_r <= ST_RUN;
            req_r   <= 1'b0;
            src_r   <= SRC_NONE;
          end
        end
        default:
        begin
          state_r <= ST_RUN;
          req_r   <= 1'b0;
          src_r   <= SRC_NONE;
        end
      endcase
    end
  end

  assign irq_req_out    = req_r & global_en_r & (|(pending & (7'h01 << src_r)));
  assign irq_src_out    = src_r;
  assign irq_vector_out = src_r;
  assign irq_out        = global_en_r & (|pending);

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      wake_r <= 1'b0;
    else
      wake_r <= |(set_vec & ~flag_r);
  end
  assign wake_out = wake_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_r <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        ADDR_W'(`IRQ_ADDR_EDGE_SEL):
          rdata_r <= {6'h00, edge_sel_r};
        ADDR_W'(`IRQ_ADDR_CTRL_FIRST):
          rdata_r <= {1'b0, flag_r[SRC_AUTO], flag_r[SRC_CONV], flag_r[SRC_EXT],
                      enable_r[SRC_AUTO], enable_r[SRC_CONV], enable_r[SRC_EXT], global_en_r};
        ADDR_W'(`IRQ_ADDR_CTRL_SECOND):
          rdata_r <= {flag_r[SRC_CMPA], flag_r[SRC_PER], flag_r[SRC_TB1], flag_r[SRC_TB0],
                      enable_r[SRC_CMPA], enable_r[SRC_PER], enable_r[SRC_TB1],
                      enable_r[SRC_TB0]};
        ADDR_W'(`IRQ_ADDR_VECTOR):
          rdata_r <= {4'h0, req_r, src_r};
        default:
          rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end
  assign rdata_out = rdata_r;

  property p_global_blocks;
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_RUN && !global_en_r) |=> !irq_req_out;
  endproperty
  a_global_blocks: assert property (p_global_blocks)
    else $error("request raised with global enable low");
  property p_request_enabled;
    @(posedge clk_in) disable iff (!reset_n_in)
    irq_req_out |-> (flag_r[src_r] && enable_r[src_r] && global_en_r);
  endproperty
  a_request_enabled: assert property (p_request_enabled)
    else $error("request for disabled source");
  property p_clear_on_take;
    @(posedge clk_in) disable iff (!reset_n_in)
    take |=> !global_en_r;
  endproperty
  a_clear_on_take: assert property (p_clear_on_take)
    else $error("global enable not cleared on entry");
  property p_flag_sets;
    @(posedge clk_in) disable iff (!reset_n_in)
    events[SRC_CONV] |=> flag_r[SRC_CONV];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("converter flag not set");
  property p_ext_flag;
    @(posedge clk_in) disable iff (!reset_n_in)
    ext_event |=> flag_r[SRC_EXT];
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external flag not set");
  property p_edge_off;
    @(posedge clk_in) disable iff (!reset_n_in)
    (edge_sel_r == `IRQ_EDGE_OFF) |-> !ext_event;
  endproperty
  a_edge_off: assert property (p_edge_off)
    else $error("edge event while disabled");
  property p_wake;
    @(posedge clk_in) disable iff (!reset_n_in)
    (|(flag_r & ~$past(flag_r))) |-> wake_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on new flag");
  property p_priority;
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_RUN && global_en_r && pending[SRC_EXT]) |=> src_r == SRC_EXT;
  endproperty
  a_priority: assert property (p_priority)
    else $error("priority order violated");
  property p_edge_read;
    @(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == ADDR_W'(`IRQ_ADDR_EDGE_SEL)) |=> rdata_out[7:2] == 6'h00;
  endproperty
  a_edge_read: assert property (p_edge_read)
    else $error("edge select upper bits nonzero");
  property p_auto_read;
    @(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == ADDR_W'(`IRQ_ADDR_CTRL_FIRST)) |=>
      rdata_out[`IRQ_B_AUTO_FLAG] == $past(flag_r[SRC_AUTO]);
  endproperty
  a_auto_read: assert property (p_auto_read)
    else $error("auto flag read mismatch");
endmodule
`default_nettype wire

// File: tb/core_model.sv
// processor core stand-in that takes the vector after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  input  wire logic       clk_in,       // system clock
  input  wire logic       reset_n_in,   // async reset, active low
  input  wire logic       irq_req_in,   // vector request from controller
  input  wire logic [1:0] ack_delay_in, // cycles to wait before taking it
  output logic            irq_ack_out   // one-cycle take pulse
);
  logic [1:0] wait_r;
  // handler entry: pulse while request stands, never on two cycles in a row; pulses again if the request stays
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wait_r      <= 2'h0;
      irq_ack_out <= 1'b0;
    end
    else
    begin
      irq_ack_out <= 1'b0;
      if (irq_req_in && !irq_ack_out)
      begin
        if (wait_r >= ack_delay_in)
        begin
          irq_ack_out <= 1'b1;
          wait_r      <= 2'h0;
        end
        else
          wait_r <= wait_r + 2'h1;
      end
      else
        wait_r <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: tb/irq_request_ctrl_tb.sv
// self-checking bench for the interrupt request controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_cfg.svh"
module irq_request_ctrl_tb;
  import irq_ctrl_pkg::*;
  logic       clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       rd_d = 1'b0;
  logic       pin = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [1:0] ack_dly = 2'h0;
  logic [7:0] rdata;
  logic       irq_req;
  logic       irq_ack;
  logic       wake;
  logic       irq_line;
  irq_src_t   src;
  logic [2:0] vec;
  logic [7:0] rq[$];
  logic [7:0] vq[$];
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;
  int unsigned seed_v;
  int         n;
  logic [7:0] exp_src;
  always #10 clk_in = ~clk_in;
  irq_request_ctrl dut
  (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_pin_in(pin),
    .conv_done_in(ev[0]), .autoconv_in(ev[1]), .timebase0_in(ev[2]),
    .timebase1_in(ev[3]), .period_match_in(ev[4]), .compare_a_in(ev[5]),
    .irq_req_out(irq_req), .irq_src_out(src), .irq_vector_out(vec),
    .irq_ack_in(irq_ack), .wake_out(wake), .irq_out(irq_line)
  );
  core_model core
  (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .irq_req_in(irq_req),
    .ack_delay_in(ack_dly), .irq_ack_out(irq_ack)
  );
  task automatic report_and_stop;
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd <= 1'b1; addr <= a; rq.push_back(e);
    @(posedge clk_in);
    rd <= 1'b0;
  endtask
  task automatic pulse(input int i, input logic w);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
    #1 chk(wake, w);
  endtask
  function automatic logic [7:0] left(input int k);
    return (k < 1 ? 8'h20 : 8'h00) | (k < 2 ? 8'h40 : 8'h00);
  endfunction
  // read data and vector source checked against the oldest note
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
    if (rd_d)
      chk(rdata, rq.pop_front());
    if (irq_ack === 1'b1)
    begin
      exp_src = vq.pop_front();
      chk({5'h00, src}, exp_src);
      chk({5'h00, vec}, exp_src);
    end
    rd_d <= rd;
  end
  initial
  begin
    seed_v = $urandom(25);
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_reg(`IRQ_ADDR_EDGE_SEL, `IRQ_RST_EDGE_SEL);
    rd_reg(`IRQ_ADDR_CTRL_FIRST, `IRQ_RST_CTRL_FIRST);
    rd_reg(`IRQ_ADDR_CTRL_SECOND, `IRQ_RST_CTRL_SECOND);
    rd_reg(`IRQ_ADDR_VECTOR, 8'h07);
    rd_reg(4'h9, 8'h00);
    wr_reg(`IRQ_ADDR_EDGE_SEL, 8'hFF);
    rd_reg(`IRQ_ADDR_EDGE_SEL, 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(`IRQ_ADDR_EDGE_SEL, s[7:0]);
      wr_reg(`IRQ_ADDR_CTRL_FIRST, 8'h00);
      pin <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd_reg(`IRQ_ADDR_CTRL_FIRST, s[0] ? 8'h10 : 8'h00);
      wr_reg(`IRQ_ADDR_CTRL_FIRST, 8'h00);
      pin <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd_reg(`IRQ_ADDR_CTRL_FIRST, s[1] ? 8'h10 : 8'h00);
    end
    wr_reg(`IRQ_ADDR_CTRL_FIRST, 8'h00);
    for (int i = 0; i < 6; i++)
      pulse(i, 1'b1);
    pulse(0, 1'b0);
    chk(irq_line, 1'b0);
    rd_reg(`IRQ_ADDR_CTRL_FIRST, 8'h60);
    rd_reg(`IRQ_ADDR_CTRL_SECOND, 8'hF0);
    wr_reg(`IRQ_ADDR_CTRL_FIRST, 8'h00);
    rd_reg(`IRQ_ADDR_CTRL_FIRST, 8'h00);
    wr_reg(`IRQ_ADDR_CTRL_SECOND, 8'hFF);
    wr_reg(`IRQ_ADDR_CTRL_FIRST, 8'h7E);
    repeat (3) @(posedge clk_in);
    chk(irq_req, 1'b0);
    chk(irq_line, 1'b0);
    for (int k = 0; k < 7; k++)
    begin
      ack_dly <= $urandom_range(0, 3);
      vq.push_back(k[7:0]);
      wr_reg(`IRQ_ADDR_CTRL_FIRST, k == 0 ? 8'h7F : 8'h0F | left(k - 1));
      #1 chk(irq_line, 1'b1);
      n = 0;
      while (irq_ack !== 1'b1 && n < 20)
      begin
        @(posedge clk_in);
        n++;
      end
      chk(irq_ack, 1'b1);
      rd_reg(`IRQ_ADDR_CTRL_FIRST, 8'h0E | left(k));
      chk(irq_line, 1'b0);
    end
    rd_reg(`IRQ_ADDR_CTRL_SECOND, 8'h0F);
    repeat (3) @(posedge clk_in);
    report_and_stop();
  end
endmodule
`default_nettype wire
